// ==== pkg/swi_params.svh ====
`ifndef SWI_PARAMS_SVH
`define SWI_PARAMS_SVH
// Register indices on the plain port
`define SWI_ADDR_FLAGS1    3'h0
`define SWI_ADDR_FLAGS2    3'h1
`define SWI_ADDR_INTCTL    3'h2
`define SWI_ADDR_OPTION    3'h3
`define SWI_ADDR_EN1       3'h4
`define SWI_ADDR_EN2       3'h5
`define SWI_ADDR_STATUS    3'h6
// Field masks and positions
`define SWI_FLAGS1_WMASK   8'hcf
`define SWI_FLAGS2_MASK    8'h89
`define SWI_GIE_BIT        7
`define SWI_PERIPHERAL_IRQ_ENABLE_BIT       6
`define SWI_PD_BIT         3
`define SWI_TO_BIT         4
`define SWI_RESET_BYTE     8'h00
`define SWI_STATUS_RESET   8'h18
`define SWI_VECTOR_ADDR    15'h0004
`define SWI_PC_ONE         15'h0001
// Start-up delay: 1024 oscillator periods
`define SWI_OST_PERIODS    11'h400
`define SWI_FORCED_NOPS    2'h2
`endif

// ==== pkg/swi_pkg.sv ====
`default_nettype none
package swi_pkg;
	typedef enum logic [4:0] {
		SWI_RUN   = 5'h01,
		SWI_SLEEP = 5'h02,
		SWI_OST   = 5'h04,
		SWI_POST  = 5'h08,
		SWI_NOPS  = 5'h10
	} swi_state_type;

	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [2:0] addr;
		logic [7:0] wdata;
	} swi_bus_type;
endpackage
`default_nettype wire

// ==== logic/swi_sleep_wake.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "swi_params.svh"
module swi_sleep_wake
	import swi_pkg::*;
(
	input  wire logic        i_clk,
	input  wire logic        i_rst_b,
	input  wire logic        i_sleep_exec,
	input  wire logic [14:0] i_pc,
	input  wire logic        i_ext_irq,
	input  wire logic        i_wdt_sleep_en,
	input  wire logic        i_wdt_timeout,
	input  wire logic        i_ost_used,
	input  wire logic        i_osc_tick,
	input  wire logic [7:0]  i_flags1_set,
	input  wire logic [7:0]  i_flags2_set,
	input  wire logic [7:0]  i_port_out,
	input  wire logic [7:0]  i_port_oe,
	input  wire logic        i_wr,
	input  wire logic        i_rd,
	input  wire logic [2:0]  i_addr,
	input  wire logic [7:0]  i_wdata,
	output logic [7:0]       o_rdata,
	output logic             o_cpu_clk_en,
	output logic             o_wdt_clear,
	output logic             o_wdt_run,
	output logic             o_prefetch,
	output logic [14:0]      o_fetch_addr,
	output logic             o_forced_nop,
	output logic             o_vector,
	output logic             o_irq,
	output logic             o_asleep,
	output logic [7:0]       o_port_out,
	output logic [7:0]       o_port_oe
);
	// Reset release through two flops; pin/brownout/POR arrive here alike
	logic rst_meta_r;
	logic rst_b_r;
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			rst_meta_r <= 1'b0;
			rst_b_r    <= 1'b0;
		end else begin
			rst_meta_r <= 1'b1;
			rst_b_r    <= rst_meta_r;
		end
	end

	swi_bus_type bus;
	assign bus = '{wr: i_wr, rd: i_rd, addr: i_addr, wdata: i_wdata};

	logic [7:0]    flags1_r, flags1_nxt, flags2_r, flags2_nxt;
	logic [7:0]    intctl_r, intctl_nxt, option_r, option_nxt;
	logic [7:0]    en1_r, en1_nxt, en2_r, en2_nxt, status_r, status_nxt;
	logic [7:0]    rdata_nxt;
	swi_state_type state_r, state_nxt;
	logic [10:0]   ost_r, ost_nxt;
	logic [1:0]    nop_r, nop_nxt;
	logic          pend_any, wake_req, enter, wake_ext, wdt_wake;
	logic          clk_en_nxt, wclr_nxt, prefetch_nxt, fnop_nxt, vec_nxt, irq_nxt;
	logic          vec_pending_r, vec_pending_nxt;
	logic [14:0]   fetch_nxt;
	logic [14:0]   sleep_pc_r, sleep_pc_nxt;
	logic [7:0]    port_out_nxt, port_oe_nxt;

	// Request needs flag, enable and peripheral enable
	assign pend_any = ((|(flags1_r & en1_r)) || (|(flags2_r & en2_r & `SWI_FLAGS2_MASK)))
		&& intctl_r[`SWI_PERIPHERAL_IRQ_ENABLE_BIT];
	// Wake ignores global enable
	assign wake_ext = i_ext_irq;
	assign wdt_wake = i_wdt_timeout && i_wdt_sleep_en;
	assign wake_req = pend_any || wake_ext || wdt_wake;
	// Sleep only on the instruction; pending+GLOBAL_IRQ_ENABLE clear is a no-op
	assign enter = i_sleep_exec && (state_r == SWI_RUN)
		&& !(pend_any && !intctl_r[`SWI_GIE_BIT]);

	// Register file next values; hardware set beats software clear
	always_comb begin
		flags1_nxt = flags1_r;
		flags2_nxt = flags2_r;
		intctl_nxt = intctl_r;
		option_nxt = option_r;
		en1_nxt    = en1_r;
		en2_nxt    = en2_r;
		status_nxt = status_r;
		rdata_nxt  = `SWI_RESET_BYTE;
		if (bus.wr) begin
			unique case (bus.addr)
				`SWI_ADDR_FLAGS1: flags1_nxt = (flags1_r & ~`SWI_FLAGS1_WMASK)
					| (bus.wdata & `SWI_FLAGS1_WMASK);
				`SWI_ADDR_FLAGS2: flags2_nxt = bus.wdata & `SWI_FLAGS2_MASK;
				`SWI_ADDR_INTCTL: intctl_nxt = bus.wdata;
				`SWI_ADDR_OPTION: option_nxt = bus.wdata;
				`SWI_ADDR_EN1:    en1_nxt    = bus.wdata;
				`SWI_ADDR_EN2:    en2_nxt    = bus.wdata & `SWI_FLAGS2_MASK;
				default: ;
			endcase
		end
		flags1_nxt = flags1_nxt | i_flags1_set;
		flags2_nxt = flags2_nxt | (i_flags2_set & `SWI_FLAGS2_MASK);
		if (enter) begin
			status_nxt[`SWI_PD_BIT] = 1'b0;
			status_nxt[`SWI_TO_BIT] = 1'b1;
		end
		if (bus.rd) begin
			unique case (bus.addr)
				`SWI_ADDR_FLAGS1: rdata_nxt = flags1_r;
				`SWI_ADDR_FLAGS2: rdata_nxt = flags2_r & `SWI_FLAGS2_MASK;
				`SWI_ADDR_INTCTL: rdata_nxt = intctl_r;
				`SWI_ADDR_OPTION: rdata_nxt = option_r;
				`SWI_ADDR_EN1:    rdata_nxt = en1_r;
				`SWI_ADDR_EN2:    rdata_nxt = en2_r;
				`SWI_ADDR_STATUS: rdata_nxt = status_r;
				default:          rdata_nxt = `SWI_RESET_BYTE;
			endcase
		end
	end

	// All flag and enable registers clear on every reset type
	always_ff @(posedge i_clk or negedge rst_b_r) begin
		if (!rst_b_r) begin
			flags1_r <= `SWI_RESET_BYTE;
			flags2_r <= `SWI_RESET_BYTE;
			intctl_r <= `SWI_RESET_BYTE;
			option_r <= `SWI_RESET_BYTE;
			en1_r    <= `SWI_RESET_BYTE;
			en2_r    <= `SWI_RESET_BYTE;
			status_r <= `SWI_STATUS_RESET;
			o_rdata  <= `SWI_RESET_BYTE;
		end else begin
			flags1_r <= flags1_nxt;
			flags2_r <= flags2_nxt;
			intctl_r <= intctl_nxt;
			option_r <= option_nxt;
			en1_r    <= en1_nxt;
			en2_r    <= en2_nxt;
			status_r <= status_nxt;
			o_rdata  <= rdata_nxt;
		end
	end

	// Sleep/wake sequencer; start-up count runs on oscillator ticks
	always_comb begin
		state_nxt       = state_r;
		ost_nxt         = ost_r;
		nop_nxt         = nop_r;
		vec_pending_nxt = vec_pending_r;
		sleep_pc_nxt    = sleep_pc_r;
		clk_en_nxt      = 1'b1;
		wclr_nxt        = 1'b0;
		prefetch_nxt    = 1'b0;
		fnop_nxt        = 1'b0;
		vec_nxt         = 1'b0;
		fetch_nxt       = o_fetch_addr;
		port_out_nxt    = i_port_out;
		port_oe_nxt     = i_port_oe;
		unique case (state_r)
			SWI_RUN: begin
				if (enter) begin
					state_nxt    = SWI_SLEEP;
					wclr_nxt     = 1'b1;
					prefetch_nxt = 1'b1;
					fetch_nxt    = i_pc + `SWI_PC_ONE;
					sleep_pc_nxt = i_pc + `SWI_PC_ONE;
					clk_en_nxt   = 1'b0;
					port_out_nxt = o_port_out;
					port_oe_nxt  = o_port_oe;
				end
			end
			SWI_SLEEP: begin
				clk_en_nxt   = 1'b0;
				port_out_nxt = o_port_out;
				port_oe_nxt  = o_port_oe;
				if (wake_req) begin
					wclr_nxt        = 1'b1;
					vec_pending_nxt = intctl_r[`SWI_GIE_BIT] && !wdt_wake;
					ost_nxt         = `SWI_OST_PERIODS;
					state_nxt       = i_ost_used ? SWI_OST : SWI_POST;
				end
			end
			SWI_OST: begin
				clk_en_nxt   = 1'b0;
				port_out_nxt = o_port_out;
				port_oe_nxt  = o_port_oe;
				if (i_osc_tick) begin
					ost_nxt = ost_r - 11'h001;
					if (ost_r == 11'h001) begin
						state_nxt = SWI_POST;
					end
				end
			end
			SWI_POST: begin
				// Instruction after sleep always executes first
				fetch_nxt = sleep_pc_r + `SWI_PC_ONE;
				if (vec_pending_r) begin
					nop_nxt   = `SWI_FORCED_NOPS;
					state_nxt = SWI_NOPS;
				end else begin
					state_nxt = SWI_RUN;
				end
			end
			SWI_NOPS: begin
				fnop_nxt = 1'b1;
				nop_nxt  = nop_r - 2'h1;
				if (nop_r == 2'h1) begin
					vec_nxt         = 1'b1;
					fetch_nxt       = `SWI_VECTOR_ADDR;
					vec_pending_nxt = 1'b0;
					state_nxt       = SWI_RUN;
				end
			end
			default: state_nxt = SWI_RUN;
		endcase
		// Interrupt to CPU gated by global enable while awake
		irq_nxt = pend_any && intctl_r[`SWI_GIE_BIT] && (state_nxt == SWI_RUN);
	end

	always_ff @(posedge i_clk or negedge rst_b_r) begin
		if (!rst_b_r) begin
			state_r       <= SWI_RUN;
			ost_r         <= 11'h000;
			nop_r         <= 2'h0;
			vec_pending_r <= 1'b0;
			sleep_pc_r    <= 15'h0000;
			o_cpu_clk_en  <= 1'b1;
			o_wdt_clear   <= 1'b0;
			o_wdt_run     <= 1'b1;
			o_prefetch    <= 1'b0;
			o_fetch_addr  <= 15'h0000;
			o_forced_nop  <= 1'b0;
			o_vector      <= 1'b0;
			o_irq         <= 1'b0;
			o_asleep      <= 1'b0;
			o_port_out    <= 8'h00;
			o_port_oe     <= 8'h00;
		end else begin
			state_r       <= state_nxt;
			ost_r         <= ost_nxt;
			nop_r         <= nop_nxt;
			vec_pending_r <= vec_pending_nxt;
			sleep_pc_r    <= sleep_pc_nxt;
			o_cpu_clk_en  <= clk_en_nxt;
			o_wdt_clear   <= wclr_nxt;
			// Watchdog keeps counting in sleep only if enabled
			o_wdt_run     <= (state_nxt == SWI_RUN) || i_wdt_sleep_en;
			o_prefetch    <= prefetch_nxt;
			o_fetch_addr  <= fetch_nxt;
			o_forced_nop  <= fnop_nxt;
			o_vector      <= vec_nxt;
			o_irq         <= irq_nxt;
			o_asleep      <= (state_nxt == SWI_SLEEP) || (state_nxt == SWI_OST);
			o_port_out    <= port_out_nxt;
			o_port_oe     <= port_oe_nxt;
		end
	end

	// Checks
	a_entry_clears_wdt: assert property (@(posedge i_clk) disable iff (!rst_b_r)
		enter |=> o_wdt_clear && !o_cpu_clk_en) else $error("entry without wdt clear");
	a_entry_status: assert property (@(posedge i_clk) disable iff (!rst_b_r)
		enter |=> !status_r[`SWI_PD_BIT] && status_r[`SWI_TO_BIT]) else $error("status");
	a_noop_sleep: assert property (@(posedge i_clk) disable iff (!rst_b_r)
		(i_sleep_exec && state_r == SWI_RUN && pend_any && !intctl_r[`SWI_GIE_BIT])
		|=> state_r == SWI_RUN && $stable(status_r)) else $error("sleep not a no-op");
	a_ports_hold: assert property (@(posedge i_clk) disable iff (!rst_b_r)
		(o_asleep && $past(o_asleep)) |-> $stable(o_port_out) && $stable(o_port_oe))
		else $error("port moved in sleep");
	a_wake_clears_wdt: assert property (@(posedge i_clk) disable iff (!rst_b_r)
		(state_r == SWI_SLEEP && wake_req) |=> o_wdt_clear) else $error("wake no clear");
	a_prefetch_pc: assert property (@(posedge i_clk) disable iff (!rst_b_r)
		enter |=> o_prefetch && o_fetch_addr == $past(i_pc) + `SWI_PC_ONE)
		else $error("bad prefetch");
	a_two_nops: assert property (@(posedge i_clk) disable iff (!rst_b_r)
		(state_r == SWI_POST && vec_pending_r) |=> ##1 o_forced_nop ##1 o_forced_nop && o_vector)
		else $error("vector sequence");
	a_ro_flags: assert property (@(posedge i_clk) disable iff (!rst_b_r)
		(bus.wr && bus.addr == `SWI_ADDR_FLAGS1 && i_flags1_set == 8'h00)
		|=> flags1_r[5:4] == $past(flags1_r[5:4])) else $error("ro flag written");
	a_flag_set: assert property (@(posedge i_clk) disable iff (!rst_b_r)
		(|i_flags1_set) |=> (flags1_r & $past(i_flags1_set)) == $past(i_flags1_set))
		else $error("flag lost");
	a_clk_gated: assert property (@(posedge i_clk) disable iff (!rst_b_r)
		o_asleep |-> !o_cpu_clk_en) else $error("clock on in sleep");
	// Request path and interrupt output; o_irq lags its inputs by one edge
	a_irq_needs_peripheral_irq_enable: assert property (@(posedge i_clk) disable iff (!rst_b_r)
		o_irq |-> $past(intctl_r[`SWI_PERIPHERAL_IRQ_ENABLE_BIT]))
		else $error("irq without peripheral enable");
	a_irq_needs_req: assert property (@(posedge i_clk) disable iff (!rst_b_r)
		o_irq |-> $past(pend_any))
		else $error("irq without flag and enable");
	a_flags2_unimpl: assert property (@(posedge i_clk) disable iff (!rst_b_r)
		(flags2_r & ~`SWI_FLAGS2_MASK) == `SWI_RESET_BYTE)
		else $error("unimplemented flag bit set");
	a_flag2_set: assert property (@(posedge i_clk) disable iff (!rst_b_r)
		(|(i_flags2_set & `SWI_FLAGS2_MASK)) |=> (flags2_r & $past(i_flags2_set)
		& `SWI_FLAGS2_MASK) == ($past(i_flags2_set) & `SWI_FLAGS2_MASK))
		else $error("second flag lost");
	// Sleep entry and wake-up sources
	a_sleep_by_exec: assert property (@(posedge i_clk) disable iff (!rst_b_r)
		(state_r == SWI_RUN && !i_sleep_exec) |=> state_r == SWI_RUN)
		else $error("sleep without instruction");
	a_wake_no_gie: assert property (@(posedge i_clk) disable iff (!rst_b_r)
		(state_r == SWI_SLEEP && pend_any) |=> state_r != SWI_SLEEP)
		else $error("enabled request did not wake");
	a_wake_ext_pin: assert property (@(posedge i_clk) disable iff (!rst_b_r)
		(state_r == SWI_SLEEP && i_ext_irq) |=> state_r != SWI_SLEEP)
		else $error("external interrupt did not wake");
	a_wdt_no_vector: assert property (@(posedge i_clk) disable iff (!rst_b_r)
		(state_r == SWI_SLEEP && wdt_wake) |=> !vec_pending_r)
		else $error("watchdog wake vectored");
	a_wdt_run_sleep: assert property (@(posedge i_clk) disable iff (!rst_b_r)
		o_asleep |-> o_wdt_run == $past(i_wdt_sleep_en))
		else $error("watchdog run wrong in sleep");
	// Start-up wait, resume and vector
	a_ost_load: assert property (@(posedge i_clk) disable iff (!rst_b_r)
		(state_r == SWI_SLEEP && wake_req && i_ost_used)
		|=> state_r == SWI_OST && ost_r == `SWI_OST_PERIODS)
		else $error("start-up count not loaded");
	a_ost_hold: assert property (@(posedge i_clk) disable iff (!rst_b_r)
		(state_r == SWI_OST && ost_r != 11'h001) |=> state_r != SWI_POST)
		else $error("start-up wait cut short");
	a_resume_addr: assert property (@(posedge i_clk) disable iff (!rst_b_r)
		(state_r == SWI_POST) |=> o_cpu_clk_en
		&& o_fetch_addr == $past(sleep_pc_r) + `SWI_PC_ONE)
		else $error("bad resume address");
	a_vector_addr: assert property (@(posedge i_clk) disable iff (!rst_b_r)
		o_vector |-> o_forced_nop && o_fetch_addr == `SWI_VECTOR_ADDR)
		else $error("bad vector fetch");
	a_nop_awake: assert property (@(posedge i_clk) disable iff (!rst_b_r)
		o_forced_nop |-> o_cpu_clk_en && !o_asleep)
		else $error("forced no-op while asleep");
	c_sleep_wake: cover property (@(posedge i_clk) state_r == SWI_SLEEP ##1 state_r == SWI_POST);
	c_wdt_wake: cover property (@(posedge i_clk) state_r == SWI_SLEEP && wdt_wake);
	c_ost_wait: cover property (@(posedge i_clk) state_r == SWI_OST ##1 state_r == SWI_POST);
	c_vector: cover property (@(posedge i_clk) o_vector);
	c_noop_sleep: cover property (@(posedge i_clk)
		i_sleep_exec && pend_any && !intctl_r[`SWI_GIE_BIT]);
endmodule
`default_nettype wire

// ==== dv/swi_cpu_model.sv ====
`timescale 1ns/100ps
`default_nettype none
// Core stand-in: runs the sleep instruction and drives the port pins
module swi_cpu_model #(
	parameter logic [14:0] SLEEP_PC = 15'h0123
) (
	input  wire logic        i_clk,
	input  wire logic        i_rst_b,
	input  wire logic        i_go,
	input  wire logic        i_cpu_clk_en,
	output logic             o_sleep_exec,
	output logic [14:0]      o_pc,
	output logic [7:0]       o_port_out,
	output logic [7:0]       o_port_oe
);
	assign o_pc = SLEEP_PC;
	// Sleep only by instruction; the word after it is prefetched and runs first on wake
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_sleep_exec <= 1'b0;
			o_port_out   <= 8'ha5;
			o_port_oe    <= 8'h3c;
		end else begin
			o_sleep_exec <= i_go & i_cpu_clk_en;
			// A stopped core shows junk, which must never reach the pins; the sequencer lets it out for two cycles on wake
			o_port_out   <= i_cpu_clk_en ? 8'ha5 : ~o_port_out;
			o_port_oe    <= i_cpu_clk_en ? 8'h3c : ~o_port_oe;
		end
	end
endmodule
`default_nettype wire

// ==== dv/sleep_wake_and_irq_flags_bench.sv ====
`timescale 1ns/100ps
`default_nettype none
module sleep_wake_and_irq_flags_bench;
	localparam logic [14:0] PC = 15'h0123;
	// Rows: address, write data, read-back value
	localparam logic [7:0][23:0] ROWS = {24'h00ffcf, 24'h01ff89, 24'h05ff89, 24'h04ffff,
		24'h06ff18, 24'h075500, 24'h000000, 24'h010000};
	logic        clk, rst_b, go, wr, rd, ext, wsen, wto, ost, tick, sx;
	logic        clken, wclr, wrun, pref, fnop, vec, irq, asleep;
	logic [2:0]  addr;
	logic [7:0]  wdata, f1set, f2set, rdata, pout, poe, mout, moe;
	logic [14:0] pc, faddr;
	int          n_fail, check_count, wclr_n, n, n0;

	swi_cpu_model #(.SLEEP_PC(PC)) cpu (.i_clk(clk), .i_rst_b(rst_b), .i_go(go),
		.i_cpu_clk_en(clken), .o_sleep_exec(sx), .o_pc(pc), .o_port_out(mout),
		.o_port_oe(moe));
	swi_sleep_wake dut (.i_clk(clk), .i_rst_b(rst_b), .i_sleep_exec(sx), .i_pc(pc),
		.i_ext_irq(ext), .i_wdt_sleep_en(wsen), .i_wdt_timeout(wto), .i_ost_used(ost),
		.i_osc_tick(tick), .i_flags1_set(f1set), .i_flags2_set(f2set), .i_port_out(mout),
		.i_port_oe(moe), .i_wr(wr), .i_rd(rd), .i_addr(addr), .i_wdata(wdata),
		.o_rdata(rdata), .o_cpu_clk_en(clken), .o_wdt_clear(wclr), .o_wdt_run(wrun),
		.o_prefetch(pref), .o_fetch_addr(faddr), .o_forced_nop(fnop), .o_vector(vec),
		.o_irq(irq), .o_asleep(asleep), .o_port_out(pout), .o_port_oe(poe));

	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	// Count watchdog clear pulses, since they last one cycle only
	always @(posedge clk) if (wclr === 1'b1) wclr_n++;

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			n_fail++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic complete_run;
		$display("checks %0d mismatches %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask

	task automatic cyc(input int k);
		repeat (k) @(posedge clk);
		#1;
	endtask

	task automatic wrr(input logic [2:0] a, input logic [7:0] d);
		@(posedge clk);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		wr <= 1'b0;
	endtask

	// Read data stands only in the cycle after the strobe
	task automatic rdc(input logic [2:0] a, input logic [7:0] e);
		@(posedge clk);
		rd <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd <= 1'b0;
		#1 chk(rdata, e);
	endtask

	task automatic f1(input logic [7:0] v);
		@(posedge clk);
		f1set <= v;
		@(posedge clk);
		f1set <= 8'h00;
	endtask

	task automatic sleep_go;
		@(posedge clk);
		go <= 1'b1;
		@(posedge clk);
		go <= 1'b0;
		cyc(1);
	endtask

	// Bounded wait for the core clock to come back
	task automatic wake_wait;
		n = 0;
		while (clken !== 1'b1 && n < 3000) begin
			@(posedge clk);
			#1;
			n++;
		end
	endtask

	initial begin
		#3_000_000;
		n_fail++;
		complete_run();
	end

	initial begin
		{rst_b, go, wr, rd, ext, wsen, wto, ost} = 8'h00;
		tick = 1'b1;
		addr = 3'h0;
		wdata = 8'h00;
		f1set = 8'h00;
		f2set = 8'h00;
		{n_fail, check_count, wclr_n} = 96'h0;
		repeat (12) @(posedge clk);
		rst_b <= 1'b1;
		cyc(3);
		for (int i = 7; i >= 0; i--) begin
			wrr(ROWS[i][18:16], ROWS[i][15:8]);
			rdc(ROWS[i][18:16], ROWS[i][7:0]);
		end
		// Events set flags whatever the enables say
		f1(8'hb0);
		rdc(3'h0, 8'hb0);
		wrr(3'h0, 8'h00);
		rdc(3'h0, 8'h30);
		// Second register events land only on its three bits
		f2set <= 8'hff;
		@(posedge clk);
		f2set <= 8'h00;
		rdc(3'h1, 8'h89);
		wrr(3'h1, 8'h00);
		rdc(3'h2, 8'h00);
		wrr(3'h4, 8'h0f);
		wrr(3'h2, 8'hc0);
		f1(8'h02);
		cyc(2);
		chk(irq, 1'b1);
		wrr(3'h2, 8'h80);
		cyc(2);
		chk(irq, 1'b0);
		// Pending enabled flag with global off turns sleep into nothing
		wrr(3'h2, 8'h40);
		sleep_go();
		chk(asleep, 1'b0);
		rdc(3'h6, 8'h18);
		wrr(3'h0, 8'h00);
		wrr(3'h2, 8'hc0);
		sleep_go();
		chk({asleep, clken, wclr, pref}, 4'hb);
		chk(faddr, PC + 15'h0001);
		cyc(3);
		chk({pout, poe}, 16'ha53c);
		rdc(3'h6, 8'h10);
		n0 = wclr_n;
		f1(8'h01);
		wake_wait();
		chk(faddr, PC + 15'h0002);
		chk(wclr_n, n0 + 1);
		cyc(1);
		chk(fnop, 1'b1);
		cyc(1);
		chk({fnop, vec, faddr}, {2'b11, 15'h0004});
		wrr(3'h0, 8'h00);
		// Pin wake through the start-up delay, global off
		wrr(3'h2, 8'h00);
		ost <= 1'b1;
		sleep_go();
		@(posedge clk);
		ext <= 1'b1;
		wake_wait();
		chk(n > 1024, 1'b1);
		chk(faddr, PC + 15'h0002);
		@(posedge clk);
		{ext, ost} <= 2'b00;
		cyc(1);
		chk({fnop, vec}, 2'b00);
		// Watchdog wake resumes without vectoring
		wsen <= 1'b1;
		wrr(3'h2, 8'h80);
		sleep_go();
		chk(wrun, 1'b1);
		@(posedge clk);
		wto <= 1'b1;
		@(posedge clk);
		wto <= 1'b0;
		wake_wait();
		cyc(2);
		chk({fnop, vec}, 2'b00);
		// Reset while asleep behaves as a full reset
		sleep_go();
		rst_b <= 1'b0;
		cyc(1);
		chk({asleep, clken}, 2'b01);
		repeat (12) @(posedge clk);
		rst_b <= 1'b1;
		cyc(3);
		rdc(3'h0, 8'h00);
		rdc(3'h6, 8'h18);
		complete_run();
	end
endmodule
`default_nettype wire
